/* File: shared/iofsd_regs.vh */
// How it works
// [RULE_01] code 2 drives output while ready, switched on or operation enabled
// [RULE_02] code 3 drives output only while operation enabled
// [RULE_03] code 4 drives output while move after capture active or finished
// [RULE_04] code 5 position window, code 6 velocity window drive output
// [RULE_05] code 7 velocity below threshold, code 8 current below threshold
// [RULE_06] code 13 drives output while motor is at standstill
// [RULE_07] code 14 selected error classes 1 to 4, code 16 warning
// [RULE_08] code 15 drives output while homing zero point is valid
// [RULE_09] code 22 positive motion, code 23 negative motion drive output
// [RULE_10] function write only with stage off; used after next power-on
// [RULE_11] each input passes hardware stage then software stage in series
// [RULE_12] hardware stage duration is fixed and not configurable
// [RULE_13] filter code 0 off, codes 1 to 6 give code times 0.25 ms
// [RULE_14] four independent filter settings, default 6, range 0 to 6
// [RULE_15] filter write only with stage off; takes effect immediately
// [RULE_16] function change or power-on restores filter setting to default
// [RULE_17] configuring party disables power stage before writing settings
// [RULE_18] new level passes only after stable for the full filter time
// [RULE_19] unlisted function codes are rejected, old value kept
`ifndef IOFSD_REGS_VH
`define IOFSD_REGS_VH

// ==========================================================
// parameter offsets
`define IOFSD_OFS_OUT1_FN   16'h0714
`define IOFSD_OFS_IN0_FILT  16'h0840
`define IOFSD_OFS_IN1_FILT  16'h0842
`define IOFSD_OFS_IN2_FILT  16'h0844
`define IOFSD_OFS_IN3_FILT  16'h0846
`define IOFSD_OFS_STRIDE    16'h0002

// ==========================================================
// reset values and ranges
`define IOFSD_FN_RST        16'h0003
`define IOFSD_FILT_RST      3'h6
`define IOFSD_FILT_MAX      16'h0006
`define IOFSD_FILT_W        3

// ==========================================================
// output 1 function codes
`define IOFSD_FN_FREE       16'h0001
`define IOFSD_FN_NOFAULT    16'h0002
`define IOFSD_FN_ACTIVE     16'h0003
`define IOFSD_FN_MAC        16'h0004
`define IOFSD_FN_POSWIN     16'h0005
`define IOFSD_FN_VELWIN     16'h0006
`define IOFSD_FN_VELBELOW   16'h0007
`define IOFSD_FN_CURBELOW   16'h0008
`define IOFSD_FN_HALTACK    16'h0009
`define IOFSD_FN_STANDSTILL 16'h000D
`define IOFSD_FN_SELERR     16'h000E
`define IOFSD_FN_REFOK      16'h000F
`define IOFSD_FN_SELWARN    16'h0010
`define IOFSD_FN_PREG1      16'h0012
`define IOFSD_FN_PREG2      16'h0013
`define IOFSD_FN_PREG3      16'h0014
`define IOFSD_FN_PREG4      16'h0015
`define IOFSD_FN_MOVPOS     16'h0016
`define IOFSD_FN_MOVNEG     16'h0017

// ==========================================================
// timing
`define IOFSD_CLK_NS        8
`define IOFSD_SW_STEP_NS    250000
`define IOFSD_HW_DEB_NS     100000
`define IOFSD_CNT_W         20

`endif

/* File: hdl/iofsd_debounce.v */
`timescale 1ns/1ps
`include "iofsd_regs.vh"

// ==========================================================
// stable-time filter, limit zero passes the level through
module iofsd_debounce #(
  parameter CW = `IOFSD_CNT_W
) (
  input  wire          clk_sys_i,
  input  wire          sys_rst_i,
  input  wire          din_i,
  input  wire [CW-1:0] lim_i,
  output reg           dout_o
);

  reg [CW-1:0] cnt_r;

  always @(posedge clk_sys_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      cnt_r  <= {CW{1'b0}};
      dout_o <= 1'b0;
    end else if (din_i == dout_o) begin
      cnt_r  <= {CW{1'b0}};                        // [RULE_18]
    end else if (lim_i == {CW{1'b0}}) begin
      dout_o <= din_i;
      cnt_r  <= {CW{1'b0}};
    end else if (cnt_r + 1'b1 >= lim_i) begin
      dout_o <= din_i;                             // [RULE_18]
      cnt_r  <= {CW{1'b0}};
    end else begin
      cnt_r  <= cnt_r + 1'b1;
    end
  end

endmodule // iofsd_debounce

/* File: hdl/iofsd_top.v */
`timescale 1ns/1ps
`include "iofsd_regs.vh"

// ==========================================================
// i/o function select and input debounce
module iofsd_top #(
  parameter SW_STEP_CYC = `IOFSD_SW_STEP_NS / `IOFSD_CLK_NS,
  parameter HW_DEB_CYC  = `IOFSD_HW_DEB_NS / `IOFSD_CLK_NS
) (
  input  wire        clk_sys_i,
  input  wire        sys_rst_i,
  // parameter access port
  input  wire [15:0] par_addr_i,
  input  wire [15:0] par_wdata_i,
  input  wire        par_wr_i,
  input  wire        par_rd_i,
  output reg  [15:0] par_rdata_o,
  output reg         par_ack_o,
  output reg         par_err_o,
  // drive state
  input  wire        power_on_i,
  input  wire        stage_en_i,
  input  wire [3:0]  in_func_chg_i,
  input  wire        st_ready_i,
  input  wire        st_on_i,
  input  wire        st_op_en_i,
  input  wire        free_level_i,
  input  wire        move_after_capture_i,
  input  wire        pos_win_i,
  input  wire        vel_win_i,
  input  wire        vel_below_i,
  input  wire        cur_below_i,
  input  wire        halt_ack_i,
  input  wire        standstill_i,
  input  wire        sel_err_i,
  input  wire        ref_ok_i,
  input  wire        sel_warn_i,
  input  wire [3:0]  pos_reg_ch_i,
  input  wire        mov_pos_i,
  input  wire        mov_neg_i,
  // pins
  input  wire        digital_input_0_i,
  input  wire        digital_input_1_i,
  input  wire        digital_input_2_i,
  input  wire        digital_input_3_i,
  output reg         digital_output_1_o,
  output wire [3:0]  din_filt_o
);

  localparam CW = `IOFSD_CNT_W;
  localparam FW = `IOFSD_FILT_W;

  // ==========================================================
  // function code check
  function fn_valid;
    input [15:0] c;
    begin
      case (c)
        `IOFSD_FN_FREE,
        `IOFSD_FN_NOFAULT,
        `IOFSD_FN_ACTIVE,
        `IOFSD_FN_MAC,
        `IOFSD_FN_POSWIN,
        `IOFSD_FN_VELWIN,
        `IOFSD_FN_VELBELOW,
        `IOFSD_FN_CURBELOW,
        `IOFSD_FN_HALTACK,
        `IOFSD_FN_STANDSTILL,
        `IOFSD_FN_SELERR,
        `IOFSD_FN_REFOK,
        `IOFSD_FN_SELWARN,
        `IOFSD_FN_PREG1,
        `IOFSD_FN_PREG2,
        `IOFSD_FN_PREG3,
        `IOFSD_FN_PREG4,
        `IOFSD_FN_MOVPOS,
        `IOFSD_FN_MOVNEG: fn_valid = 1'b1;
        default:          fn_valid = 1'b0;   // [RULE_19]
      endcase
    end
  endfunction

  // ==========================================================
  // filter code to cycle limit
  function [CW-1:0] filt_lim;
    input [FW-1:0] c;
    reg   [CW+FW-1:0] p;
    begin
      p = c * SW_STEP_CYC[CW-1:0];                 // [RULE_13]
      filt_lim = p[CW-1:0];
    end
  endfunction

  // ==========================================================
  // filter address decode, index or none
  function [2:0] filt_idx;
    input [15:0] a;
    begin
      case (a)
        `IOFSD_OFS_IN0_FILT: filt_idx = 3'h0;
        `IOFSD_OFS_IN1_FILT: filt_idx = 3'h1;
        `IOFSD_OFS_IN2_FILT: filt_idx = 3'h2;
        `IOFSD_OFS_IN3_FILT: filt_idx = 3'h3;
        default:             filt_idx = 3'h4;
      endcase
    end
  endfunction

  // ==========================================================
  // input synchronisers
  wire [3:0] pin_w;
  reg  [3:0] sync1_r;
  reg  [3:0] sync2_r;

  assign pin_w = {digital_input_3_i, digital_input_2_i,
                  digital_input_1_i, digital_input_0_i};

  always @(posedge clk_sys_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      sync1_r <= 4'h0;
      sync2_r <= 4'h0;
    end else begin
      sync1_r <= pin_w;
      sync2_r <= sync1_r;
    end
  end

  // ==========================================================
  // parameter registers
  reg  [15:0]   fn_store_r;
  reg  [15:0]   fn_act_r;
  reg  [4*FW-1:0] filt_r;
  wire [2:0]    wr_idx_w;
  wire [2:0]    rd_idx_w;
  wire          wr_fn_w;
  wire          wr_filt_w;
  wire          wr_ok_w;
  wire          fn_code_ok_w;
  wire          filt_val_ok_w;

  // ==========================================================
  // address decode and write acceptance
  assign wr_idx_w      = filt_idx(par_addr_i);
  assign rd_idx_w      = filt_idx(par_addr_i);
  assign wr_fn_w       = par_wr_i && (par_addr_i == `IOFSD_OFS_OUT1_FN);
  assign wr_filt_w     = par_wr_i && !wr_idx_w[2];
  assign fn_code_ok_w  = fn_valid(par_wdata_i);          // [RULE_19]
  assign filt_val_ok_w = (par_wdata_i <= `IOFSD_FILT_MAX); // [RULE_14]
  assign wr_ok_w       = !stage_en_i && // [RULE_10] [RULE_15]
                         ((wr_fn_w && fn_code_ok_w) ||
                          (wr_filt_w && filt_val_ok_w));

  // ==========================================================
  // function select, stored now and applied at power-on
  reg  [15:0]     fn_store_nxt;
  reg  [15:0]     fn_act_nxt;

  always @* begin
    fn_store_nxt = fn_store_r;
    fn_act_nxt   = fn_act_r;
    if (wr_fn_w && wr_ok_w)
      fn_store_nxt = par_wdata_i;                    // [RULE_10]
    if (power_on_i)
      fn_act_nxt = fn_store_r;                       // [RULE_10]
  end

  // ==========================================================
  // per-input filter settings, a restore wins over a write
  wire [4*FW-1:0] filt_nxt;
  genvar          gi;

  generate
    for (gi = 0; gi < 4; gi = gi + 1) begin : g_filt
      wire restore_w;
      wire sel_w;
      assign restore_w = power_on_i || in_func_chg_i[gi];
      assign sel_w     = wr_filt_w && wr_ok_w &&
                         (wr_idx_w[1:0] == gi);
      assign filt_nxt[gi*FW +: FW] =
        restore_w ? `IOFSD_FILT_RST :                // [RULE_16]
        sel_w     ? par_wdata_i[FW-1:0] :            // [RULE_15]
                    filt_r[gi*FW +: FW];
    end
  endgenerate

  // ==========================================================
  // stored settings
  always @(posedge clk_sys_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      fn_store_r <= `IOFSD_FN_RST;
      fn_act_r   <= `IOFSD_FN_RST;
      filt_r     <= {4{`IOFSD_FILT_RST}};            // [RULE_14]
    end else begin
      fn_store_r <= fn_store_nxt;
      fn_act_r   <= fn_act_nxt;
      filt_r     <= filt_nxt;
    end
  end

  // ==========================================================
  // read and answer path
  reg [15:0] rd_nxt;
  reg        err_nxt;
  reg        ack_nxt;

  always @* begin
    rd_nxt  = 16'h0000;
    err_nxt = 1'b0;
    ack_nxt = par_rd_i || par_wr_i;
    if (par_rd_i) begin
      if (par_addr_i == `IOFSD_OFS_OUT1_FN)
        rd_nxt = fn_store_r;
      else if (!rd_idx_w[2])
        rd_nxt = {{(16-FW){1'b0}},
                  filt_r[rd_idx_w[1:0]*FW +: FW]};
      else
        err_nxt = 1'b1;
    end else if (par_wr_i) begin
      err_nxt = !wr_ok_w;                            // [RULE_19]
    end
  end

  // ==========================================================
  // answer register
  always @(posedge clk_sys_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      par_rdata_o <= 16'h0000;
      par_ack_o   <= 1'b0;
      par_err_o   <= 1'b0;
    end else begin
      par_ack_o <= ack_nxt;
      par_err_o <= err_nxt;
      if (par_rd_i)
        par_rdata_o <= rd_nxt;
    end
  end

  // ==========================================================
  // hardware stage, fixed limit
  wire [3:0]      hw_out_w;
  wire [CW-1:0]   hw_lim_w;

  assign hw_lim_w = HW_DEB_CYC[CW-1:0];              // [RULE_12]

  generate
    for (gi = 0; gi < 4; gi = gi + 1) begin : g_hw
      iofsd_debounce #(
        .CW (CW)
      ) u_hw (
        .clk_sys_i (clk_sys_i),
        .sys_rst_i (sys_rst_i),
        .din_i     (sync2_r[gi]),
        .lim_i     (hw_lim_w),
        .dout_o    (hw_out_w[gi])                    // [RULE_11]
      );
    end
  endgenerate

  // ==========================================================
  // software stage limit per input
  wire [4*CW-1:0] sw_lim_w;

  generate
    for (gi = 0; gi < 4; gi = gi + 1) begin : g_lim
      assign sw_lim_w[gi*CW +: CW] =
        filt_lim(filt_r[gi*FW +: FW]);               // [RULE_13]
    end
  endgenerate

  // ==========================================================
  // software stage, in series behind the hardware stage
  generate
    for (gi = 0; gi < 4; gi = gi + 1) begin : g_sw
      iofsd_debounce #(
        .CW (CW)
      ) u_sw (
        .clk_sys_i (clk_sys_i),
        .sys_rst_i (sys_rst_i),
        .din_i     (hw_out_w[gi]),                   // [RULE_11]
        .lim_i     (sw_lim_w[gi*CW +: CW]),          // [RULE_13]
        .dout_o    (din_filt_o[gi])
      );
    end
  endgenerate

  // ==========================================================
  // output 1 source select
  reg out_nxt;

  always @* begin
    case (fn_act_r)
      `IOFSD_FN_FREE:
        out_nxt = free_level_i;
      `IOFSD_FN_NOFAULT:
        out_nxt = st_ready_i | st_on_i | st_op_en_i; // [RULE_01]
      `IOFSD_FN_ACTIVE:
        out_nxt = st_op_en_i;                        // [RULE_02]
      `IOFSD_FN_MAC:
        out_nxt = move_after_capture_i;              // [RULE_03]
      `IOFSD_FN_POSWIN:
        out_nxt = pos_win_i;                         // [RULE_04]
      `IOFSD_FN_VELWIN:
        out_nxt = vel_win_i;                         // [RULE_04]
      `IOFSD_FN_VELBELOW:
        out_nxt = vel_below_i;                       // [RULE_05]
      `IOFSD_FN_CURBELOW:
        out_nxt = cur_below_i;                       // [RULE_05]
      `IOFSD_FN_HALTACK:
        out_nxt = halt_ack_i;
      `IOFSD_FN_STANDSTILL:
        out_nxt = standstill_i;                      // [RULE_06]
      `IOFSD_FN_SELERR:
        out_nxt = sel_err_i;                         // [RULE_07]
      `IOFSD_FN_REFOK:
        out_nxt = ref_ok_i;                          // [RULE_08]
      `IOFSD_FN_SELWARN:
        out_nxt = sel_warn_i;                        // [RULE_07]
      `IOFSD_FN_PREG1:
        out_nxt = pos_reg_ch_i[0];
      `IOFSD_FN_PREG2:
        out_nxt = pos_reg_ch_i[1];
      `IOFSD_FN_PREG3:
        out_nxt = pos_reg_ch_i[2];
      `IOFSD_FN_PREG4:
        out_nxt = pos_reg_ch_i[3];
      `IOFSD_FN_MOVPOS:
        out_nxt = mov_pos_i;                         // [RULE_09]
      `IOFSD_FN_MOVNEG:
        out_nxt = mov_neg_i;                         // [RULE_09]
      default:
        out_nxt = 1'b0;
    endcase
  end

  // ==========================================================
  // output 1 register
  always @(posedge clk_sys_i or posedge sys_rst_i) begin
    if (sys_rst_i)
      digital_output_1_o <= 1'b0;
    else
      digital_output_1_o <= out_nxt;
  end

endmodule // iofsd_top

/* File: verification/iofsd_top_assertions.sv */
`timescale 1ns/1ps
// ==========================================================
// parameter port and input filter checks
module iofsd_top_chk #(
  parameter SW_STEP_CYC = 4,
  parameter HW_DEB_CYC  = 3
) (
  input wire        clk_sys_i,
  input wire        sys_rst_i,
  input wire [15:0] par_addr_i,
  input wire [15:0] par_wdata_i,
  input wire        par_wr_i,
  input wire        par_rd_i,
  input wire [15:0] par_rdata_o,
  input wire        par_ack_o,
  input wire        par_err_o,
  input wire        power_on_i,
  input wire        stage_en_i,
  input wire        digital_input_0_i,
  input wire [3:0]  din_filt_o
);
  reg [15:0] run_r;
  reg        pin_r;
  reg        ok_r;
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (sys_rst_i);
  // ==========================================================
  // run of equal pin samples, armed once long enough
  always @(posedge clk_sys_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      run_r <= 16'h0000;
      pin_r <= 1'b0;
      ok_r  <= 1'b0;
    end else begin
      pin_r <= digital_input_0_i;
      if (digital_input_0_i != pin_r) begin
        run_r <= 16'h0000;
      end else if (run_r != 16'hffff) begin
        run_r <= run_r + 16'h0001;
      end
      if ($changed(din_filt_o[0])) begin
        ok_r <= 1'b0;
      end else if (run_r + 16'h0001 >= HW_DEB_CYC) begin
        ok_r <= ok_r | (pin_r != din_filt_o[0]);
      end
    end
  end
  // ==========================================================
  // assertions
  sequence s_req;
    par_wr_i || par_rd_i;
  endsequence
  sequence s_pon_rd;
    power_on_i ##1 (par_rd_i && par_addr_i == 16'h0840);
  endsequence
  AST_ACK: assert property (s_req |=> par_ack_o)
    else $error("answer missing");
  AST_NO_ACK: assert property (!(par_wr_i || par_rd_i) |=> !par_ack_o)
    else $error("answer without request");
  AST_ERR_ACK: assert property (par_err_o |-> par_ack_o)
    else $error("refusal without answer");
  AST_STAGE: assert property (par_wr_i && stage_en_i |=> par_err_o)
    else $error("write accepted with stage on");
  AST_FMAX: assert property (par_wr_i && par_addr_i[15:4] == 12'h084
    && par_wdata_i > 16'h0006 |=> par_err_o)
    else $error("filter value above range accepted");
  AST_FBAD: assert property (par_wr_i && par_addr_i == 16'h0714
    && par_wdata_i inside {16'h0000, [16'h000A:16'h000C], 16'h0011,
    [16'h0018:16'hFFFF]} |=> par_err_o)
    else $error("unlisted function code accepted");
  AST_RD_HI: assert property (par_rd_i && par_addr_i[15:4] == 12'h084
    |=> par_rdata_o[15:3] == 13'h0000)
    else $error("filter upper bits not zero");
  AST_PON: assert property (s_pon_rd |=> par_rdata_o == 16'h0006)
    else $error("filter not restored at power-on");
  AST_DIN: assert property ($changed(din_filt_o[0]) |-> ok_r)
    else $error("filtered input moved without stable run");
endmodule // iofsd_top_chk

bind iofsd_top iofsd_top_chk #(
  .SW_STEP_CYC(SW_STEP_CYC),
  .HW_DEB_CYC (HW_DEB_CYC)
) u_chk (
  .clk_sys_i         (clk_sys_i),
  .sys_rst_i         (sys_rst_i),
  .par_addr_i        (par_addr_i),
  .par_wdata_i       (par_wdata_i),
  .par_wr_i          (par_wr_i),
  .par_rd_i          (par_rd_i),
  .par_rdata_o       (par_rdata_o),
  .par_ack_o         (par_ack_o),
  .par_err_o         (par_err_o),
  .power_on_i        (power_on_i),
  .stage_en_i        (stage_en_i),
  .digital_input_0_i (digital_input_0_i),
  .din_filt_o        (din_filt_o)
);

/* File: verification/iofsd_switch_model.sv */
`timescale 1ns/1ps
// ==========================================================
// switch bank on the inputs, chatters on request
module iofsd_switch_model (
  input  wire       clk_sys_i,
  input  wire [3:0] level_i,
  input  wire [3:0] bounce_i,
  input  wire [7:0] bounce_len_i,
  output reg  [3:0] pin_o
);
  reg [7:0] cnt_r = 8'h00;
  reg [3:0] mask_r = 4'h0;
  initial pin_o = 4'h0;
  always @(posedge clk_sys_i) begin
    if (bounce_i != 4'h0) begin
      cnt_r  <= bounce_len_i;
      mask_r <= bounce_i;
    end else if (cnt_r != 8'h00) begin
      cnt_r <= cnt_r - 8'h01;
    end
    if (cnt_r != 8'h00) begin
      pin_o <= pin_o ^ mask_r;
    end else begin
      pin_o <= level_i;
    end
  end
endmodule // iofsd_switch_model

/* File: verification/test_io_function_select_debounce.sv */
`timescale 1ns/1ps
// ==========================================================
// bench
module test_io_function_select_debounce;
  localparam [151:0] CODES = {8'h17, 8'h16, 8'h15, 8'h14, 8'h13, 8'h12,
    8'h10, 8'h0F, 8'h0E, 8'h0D, 8'h09, 8'h08, 8'h07, 8'h06, 8'h05, 8'h04,
    8'h03, 8'h02, 8'h01};
  reg clk_sys_i = 1'b0;
  reg sys_rst_i = 1'b1;
  reg [15:0] par_addr_i = 16'h0000;
  reg [15:0] par_wdata_i = 16'h0000;
  reg par_wr_i = 1'b0;
  reg par_rd_i = 1'b0;
  reg power_on_i = 1'b0;
  reg stage_en_i = 1'b0;
  reg [3:0] in_func_chg_i = 4'h0;
  reg [19:0] src_r = 20'h0_0000;
  reg [3:0] lvl_r = 4'h0;
  reg [3:0] bnc_r = 4'h0;
  reg [31:0] seed_r = 32'h0000_ad6c;
  reg [17:0] exp_q[$];
  reg [17:0] e;
  reg [15:0] prev;
  reg [3:0] seen;
  integer errors = 0;
  integer samples_checked = 0;
  integer k;
  integer n;
  wire [15:0] par_rdata_o;
  wire par_ack_o;
  wire par_err_o;
  wire out1;
  wire [3:0] pin;
  wire [3:0] din_filt_o;
  iofsd_top #(.SW_STEP_CYC(4), .HW_DEB_CYC(3)) i_dut (
    .clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i), .par_addr_i(par_addr_i),
    .par_wdata_i(par_wdata_i), .par_wr_i(par_wr_i), .par_rd_i(par_rd_i),
    .par_rdata_o(par_rdata_o), .par_ack_o(par_ack_o),
    .par_err_o(par_err_o), .power_on_i(power_on_i),
    .stage_en_i(stage_en_i), .in_func_chg_i(in_func_chg_i),
    .st_ready_i(src_r[0]), .st_on_i(src_r[1]), .st_op_en_i(src_r[2]),
    .free_level_i(src_r[3]), .move_after_capture_i(src_r[4]),
    .pos_win_i(src_r[5]), .vel_win_i(src_r[6]), .vel_below_i(src_r[7]),
    .cur_below_i(src_r[8]), .halt_ack_i(src_r[9]),
    .standstill_i(src_r[10]), .sel_err_i(src_r[11]),
    .ref_ok_i(src_r[12]), .sel_warn_i(src_r[13]),
    .pos_reg_ch_i(src_r[19:16]), .mov_pos_i(src_r[14]),
    .mov_neg_i(src_r[15]), .digital_input_0_i(pin[0]),
    .digital_input_1_i(pin[1]), .digital_input_2_i(pin[2]),
    .digital_input_3_i(pin[3]), .digital_output_1_o(out1),
    .din_filt_o(din_filt_o));
  iofsd_switch_model i_sw (.clk_sys_i(clk_sys_i), .level_i(lvl_r),
    .bounce_i(bnc_r), .bounce_len_i(8'h14), .pin_o(pin));
  initial begin
    forever #4 clk_sys_i = ~clk_sys_i;
  end
  function [31:0] lfsr(input [31:0] s);
    lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function exp_out(input [15:0] c, input [19:0] s);
    case (c)
      16'h0001: exp_out = s[3];
      16'h0009: exp_out = s[9];
      16'h0012, 16'h0013, 16'h0014, 16'h0015: exp_out = s[c - 2];
      16'h0002: exp_out = |s[2:0];
      16'h0003: exp_out = s[2];
      16'h0004: exp_out = s[4];
      16'h0005, 16'h0006: exp_out = s[c];
      16'h0007, 16'h0008: exp_out = s[c];
      16'h000D: exp_out = s[10];
      16'h000E, 16'h0010: exp_out = s[c - 3];
      16'h000F: exp_out = s[12];
      default: exp_out = s[c - 8];
    endcase
  endfunction
  task check(input string what, input [15:0] seen_v, input [15:0] exp_v);
    begin
      samples_checked = samples_checked + 1;
      if (seen_v !== exp_v) begin
        errors = errors + 1;
        $display("CHECK FAILED %s expected %h seen %h", what, exp_v, seen_v);
      end
    end
  endtask
  task acc(input wr, input [15:0] a, input [15:0] d, input er,
    input [15:0] rd);
    begin
      @(posedge clk_sys_i);
      par_wr_i <= wr;
      par_rd_i <= !wr;
      par_addr_i <= a;
      par_wdata_i <= d;
      exp_q.push_back({!wr, er, rd});
      @(posedge clk_sys_i);
      par_wr_i <= 1'b0;
      par_rd_i <= 1'b0;
    end
  endtask
  task sample(input [15:0] c);
    begin
      @(posedge clk_sys_i);
      seed_r = lfsr(seed_r);
      src_r <= seed_r[19:0];
      repeat (2) @(posedge clk_sys_i);
      check("output1", {15'h0000, out1}, {15'h0000, exp_out(c, src_r)});
    end
  endtask
  task report_and_stop;
    begin
      if (errors == 0 && samples_checked > 0) begin
        $display("Run complete: PASS");
      end else begin
        $display("Run complete: FAIL");
      end
      $finish;
    end
  endtask
  // ==========================================================
  // answer monitor
  always @(posedge clk_sys_i) begin
    if (par_ack_o === 1'b1) begin
      check("queue", {15'h0000, exp_q.size() != 0}, 16'h0001);
      e = (exp_q.size() == 0) ? 18'h1_0000 : exp_q.pop_front();
      check("err", {15'h0000, par_err_o}, {15'h0000, e[16]});
      if (e[17]) check("rdata", par_rdata_o, e[15:0]);
    end
  end
  initial begin
    repeat (5000) @(posedge clk_sys_i);
    errors = errors + 1;
    report_and_stop;
  end
  // ==========================================================
  // main sequence
  initial begin
    repeat (8) @(posedge clk_sys_i);
    sys_rst_i <= 1'b0;
    acc(0, 16'h0714, 0, 0, 16'h0003);
    for (k = 0; k < 4; k = k + 1) acc(0, 16'h0840 + 2 * k, 0, 0, 16'h0006);
    acc(0, 16'h0700, 0, 1, 16'h0000);
    acc(1, 16'h0700, 16'h0005, 1, 0);
    stage_en_i <= 1'b1;
    acc(1, 16'h0840, 16'h0002, 1, 0);
    acc(1, 16'h0714, 16'h0002, 1, 0);
    stage_en_i <= 1'b0;
    acc(0, 16'h0840, 0, 0, 16'h0006);
    acc(1, 16'h0842, 16'h0007, 1, 0);
    for (k = 0; k < 7; k = k + 1) begin
      acc(1, 16'h0846, k, 0, 0);
      acc(0, 16'h0846, 0, 0, k);
    end
    acc(1, 16'h0714, 16'h000A, 1, 0);
    acc(1, 16'h0714, 16'h0011, 1, 0);
    acc(0, 16'h0714, 0, 0, 16'h0003);
    prev = 16'h0003;
    for (k = 0; k < 19; k = k + 1) begin
      acc(1, 16'h0714, {8'h00, CODES[k * 8 +: 8]}, 0, 0);
      acc(1, 16'h0840, 16'h0002, 0, 0);
      repeat (2) sample(prev);
      @(posedge clk_sys_i);
      power_on_i <= 1'b1;
      @(posedge clk_sys_i);
      power_on_i <= 1'b0;
      par_rd_i <= 1'b1;
      par_addr_i <= 16'h0840;
      exp_q.push_back({2'b10, 16'h0006});
      @(posedge clk_sys_i);
      par_rd_i <= 1'b0;
      prev = {8'h00, CODES[k * 8 +: 8]};
      repeat (4) sample(prev);
    end
    acc(1, 16'h0840, 16'h0002, 0, 0);
    acc(1, 16'h0842, 16'h0000, 0, 0);
    bnc_r <= 4'h1;
    @(posedge clk_sys_i);
    bnc_r <= 4'h0;
    repeat (30) @(posedge clk_sys_i);
    lvl_r <= 4'h3;
    repeat (6) @(posedge clk_sys_i);
    lvl_r <= 4'h0;
    seen = din_filt_o;
    repeat (20) @(posedge clk_sys_i) seen = seen | din_filt_o;
    check("pulse", {14'h0000, seen[1:0]}, 16'h0002);
    lvl_r <= 4'h1;
    n = 0;
    while (din_filt_o[0] !== 1'b1 && n < 40) begin
      @(posedge clk_sys_i);
      n = n + 1;
    end
    check("delay", n[15:0], 16'h000F);
    in_func_chg_i <= 4'h2;
    @(posedge clk_sys_i);
    in_func_chg_i <= 4'h0;
    acc(0, 16'h0842, 0, 0, 16'h0006);
    acc(0, 16'h0840, 0, 0, 16'h0002);
    repeat (4) @(posedge clk_sys_i);
    check("pending", exp_q.size(), 16'h0000);
    report_and_stop;
  end
endmodule // test_io_function_select_debounce
